/* rtl/seq_pkg.sv */
package seq_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CMD   = 8'h04;
  localparam logic [7:0] A_SEL   = 8'h08;
  localparam logic [7:0] A_ONCE  = 8'h0c;
  localparam logic [7:0] A_TADDR = 8'h10;
  localparam logic [7:0] A_TDATA = 8'h14;
  localparam logic [7:0] A_SDEF  = 8'h18;
  localparam logic [7:0] A_SYNC  = 8'h1c;
  localparam logic [7:0] A_STAT  = 8'h20;
  localparam logic [7:0] A_PTS   = 8'h24;
  // Field widths
  localparam int IW = 10;
  localparam int SW = 8;
  localparam int RW = 20;
  localparam int CW = 11;
  localparam int EW = 29;
  // Control field positions
  localparam int P_MODE  = 0;
  localparam int P_ADVT  = 2;
  localparam int P_SRC   = 3;
  localparam int P_IMM   = 4;
  localparam int P_JSRC  = 5;
  localparam int P_RUN   = 7;
  localparam int P_SLOCK = 9;
  localparam int P_COUP  = 10;
  // Command bits
  localparam int P_APPLY = 0;
  localparam int P_START = 1;
  localparam int P_ABORT = 2;
  localparam int P_JUMP  = 3;
  // Table entry and sequence definition fields
  localparam int P_SEG   = 0;
  localparam int P_REP   = 8;
  localparam int P_JBIT  = 28;
  localparam int P_SIDX  = 0;
  localparam int P_FIRST = 10;
  localparam int P_LAST  = 20;
  // Modes
  localparam logic [1:0] ADV_AUTO = 2'h0;
  localparam logic [1:0] ADV_ONCE = 2'h1;
  localparam logic [1:0] ADV_STEP = 2'h2;
  localparam logic [1:0] RUN_CONT = 2'h0;
  localparam logic [1:0] JS_EVENT = 2'h0;
  localparam logic [1:0] JS_TRIG  = 2'h1;
  // Reset values
  localparam logic [CW-1:0] CTRL_RST = 11'h000;
  localparam logic [RW-1:0] ONCE_RST = 20'h00001;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_GO   = 4'b0010,
    ST_PLAY = 4'b0100,
    ST_NEXT = 4'b1000
  } seq_state_t;
endpackage : seq_pkg

/* rtl/waveform_sequence_stepper.sv */
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
// How it works
// R1: Up to 1000 sequences stored, one active sequence replayed at a time.
// R2: In coupled mode a common selection sets the active sequence.
// R3: Selection source is remote register or external select input.
// R4: Switch at sequence end (coherent, default) or immediately.
// R5: Table entry holds segment, repeat count and jump flag, indexed by step.
// R6: Steps play strictly in increasing step-index order.
// R7: Any segment may be reused; controller only places defined segments.
// R8: Each step plays its segment repeat-count complete passes, then advances.
// R9: Jump flag 1 dwells on the step until a jump event; 0 proceeds.
// R10: After a releasing jump the current pass completes before advancing.
// R11: Auto mode wraps from last step to first step forever.
// R12: Auto advance mode is the reset default.
// R13: Once mode plays one burst of once_cnt sequences per start, then idles; flags honoured.
// R14: Once mode burst count repeats whole sequence 1 to 1,000,000 times.
// R15: Once mode starts on enable in continuous, initiate otherwise.
// R16: Stepped mode treats every jump flag as set.
// R17: Jump event source is selectable, used in auto and stepped modes.
// R18: Configuration chooses normal or advanced sequence operation.
// R19: Sequence duration is total played sample points over sample clock.
// R20: Sync output lockable to a chosen segment or sequence.
// R21: Apply loads staged settings and restarts output at once.
// R22: External select latches 8-bit code only on the valid strobe.
// R23: Burst end or abort returns pointer and counters to the first step.
module waveform_sequence_stepper #(
  parameter int SEQ_N = 1000,
  parameter int TBL_N = 1024
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic      [seq_pkg::SW-1:0] seg_num,
  output logic                        seg_go,
  input  wire logic                   seg_end,
  input  wire logic                   sample_tick,
  output logic                        playing,
  output logic                        sync_out,
  input  wire logic                   enable_in,
  input  wire logic                   initiate_in,
  input  wire logic                   abort_in,
  input  wire logic                   trig_in,
  input  wire logic                   event_in,
  input  wire logic [7:0]             sel_code,
  input  wire logic                   sel_valid,
  input  wire logic [seq_pkg::IW-1:0] common_seq,
  input  wire logic                   common_stb
);
  typedef struct packed {
    seq_pkg::seq_state_t    st;
    logic                   ack;
    logic [31:0]            rdata;
    logic [seq_pkg::CW-1:0] ctrl;
    logic [seq_pkg::CW-1:0] ctrl_w;
    logic [seq_pkg::IW-1:0] req;
    logic                   pend;
    logic [seq_pkg::IW-1:0] act;
    logic [seq_pkg::RW-1:0] once_cnt;
    logic [seq_pkg::RW-1:0] burst;
    logic [seq_pkg::IW-1:0] taddr;
    logic [seq_pkg::IW-1:0] tgt;
    logic [seq_pkg::IW-1:0] step;
    logic [seq_pkg::RW-1:0] rep;
    logic                   jmp;
    logic [31:0]            pts;
    logic [31:0]            acc;
    logic [seq_pkg::SW-1:0] seg;
    logic                   go;
    logic                   sync;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [seq_pkg::EW-1:0] tbl [TBL_N];
  logic [seq_pkg::IW-1:0] sfirst [SEQ_N];
  logic [seq_pkg::IW-1:0] slast [SEQ_N];
  logic                   acc_en;
  logic                   wr;
  logic                   tbl_we;
  logic                   sdef_we;
  logic                   bad;
  logic [seq_pkg::EW-1:0] ent;
  logic [seq_pkg::RW-1:0] rep_e;
  logic                   flag;
  logic                   jev;
  logic                   start;
  logic                   abort;
  logic                   apply;
  logic                   busy;
  logic                   seq_end;
  logic [seq_pkg::IW-1:0] first_a;
  logic [seq_pkg::IW-1:0] first_r;
  logic [seq_pkg::IW-1:0] last_a;
  logic [31:0]            acc_in;
  logic [1:0]             mode;

  // Bus decode and current table entry
  assign acc_en  = psel & penable;
  assign wr      = acc_en & s_reg.ack & pwrite;
  assign tbl_we  = wr & (paddr == seq_pkg::A_TDATA) & (32'(s_reg.taddr) < TBL_N);
  assign sdef_we = wr & (paddr == seq_pkg::A_SDEF) & (32'(pwdata[9:0]) < SEQ_N);
  assign bad     = !(paddr inside {seq_pkg::A_CTRL, seq_pkg::A_CMD, seq_pkg::A_SEL,
                   seq_pkg::A_ONCE, seq_pkg::A_TADDR, seq_pkg::A_TDATA, seq_pkg::A_SDEF,
                   seq_pkg::A_SYNC, seq_pkg::A_STAT, seq_pkg::A_PTS});
  assign pready  = s_reg.ack;
  assign pslverr = s_reg.ack & bad;
  assign prdata  = s_reg.rdata;
  assign mode    = s_reg.ctrl[seq_pkg::P_MODE +: 2];
  assign ent     = tbl[s_reg.step];
  assign rep_e   = ent[seq_pkg::P_REP +: seq_pkg::RW];
  assign first_a = sfirst[s_reg.act];
  assign last_a  = slast[s_reg.act];
  assign first_r = sfirst[s_reg.req];
  assign busy    = (s_reg.st != seq_pkg::ST_IDLE);
  assign seq_end = (s_reg.st == seq_pkg::ST_NEXT) & (s_reg.step == last_a);
  assign acc_in  = s_reg.acc + {31'h0, sample_tick};
  // Stepped mode forces every flag [R16]
  assign flag    = ent[seq_pkg::P_JBIT] | (mode == seq_pkg::ADV_STEP); // [R9]
  // Command strobes, one cycle at the write edge; abort also follows abort_in
  assign apply   = wr & (paddr == seq_pkg::A_CMD) & pwdata[seq_pkg::P_APPLY];
  assign abort   = abort_in | (wr & (paddr == seq_pkg::A_CMD) & pwdata[seq_pkg::P_ABORT]);

  // Jump source: selectable in auto and stepped, event input in once mode
  always_comb
  begin
    if (mode == seq_pkg::ADV_ONCE)
      jev = event_in;
    else if (s_reg.ctrl[seq_pkg::P_JSRC +: 2] == seq_pkg::JS_EVENT) // [R17]
      jev = event_in;
    else if (s_reg.ctrl[seq_pkg::P_JSRC +: 2] == seq_pkg::JS_TRIG)
      jev = trig_in;
    else
      jev = wr & (paddr == seq_pkg::A_CMD) & pwdata[seq_pkg::P_JUMP];
  end

  // Start condition per run mode
  always_comb
  begin
    start = initiate_in | (wr & (paddr == seq_pkg::A_CMD) & pwdata[seq_pkg::P_START]);
    if (s_reg.ctrl[seq_pkg::P_RUN +: 2] == seq_pkg::RUN_CONT)
    begin
      if (mode == seq_pkg::ADV_ONCE)
        start = enable_in | (wr & (paddr == seq_pkg::A_CMD) & pwdata[seq_pkg::P_START]); // [R15]
      else
        start = 1'b1;
    end
  end

  // Table and sequence definition storage
  always_ff @(posedge pclk)
  begin
    if (tbl_we)
      tbl[s_reg.taddr] <= pwdata[seq_pkg::EW-1:0]; // [R5]
    if (sdef_we)
    begin
      sfirst[pwdata[seq_pkg::P_SIDX +: seq_pkg::IW]] <= pwdata[seq_pkg::P_FIRST +: seq_pkg::IW];
      slast[pwdata[seq_pkg::P_SIDX +: seq_pkg::IW]]  <= pwdata[seq_pkg::P_LAST +: seq_pkg::IW];
    end
  end

  // Next-state logic: bus, selection and sequencer
  always_comb
  begin
    s_next      = s_reg;
    s_next.go   = 1'b0;
    s_next.ack  = acc_en & !s_reg.ack;
    // Read data captured in the first access cycle
    if (acc_en & !s_reg.ack)
    begin
      case (paddr)
        seq_pkg::A_CTRL:  s_next.rdata = {21'h0, s_reg.ctrl_w};
        seq_pkg::A_SEL:   s_next.rdata = {22'h0, s_reg.req};
        seq_pkg::A_ONCE:  s_next.rdata = {12'h0, s_reg.once_cnt};
        seq_pkg::A_TADDR: s_next.rdata = {22'h0, s_reg.taddr};
        seq_pkg::A_TDATA: s_next.rdata = {3'h0, tbl[s_reg.taddr]};
        seq_pkg::A_SYNC:  s_next.rdata = {22'h0, s_reg.tgt};
        seq_pkg::A_STAT:  s_next.rdata = {10'h0, s_reg.jmp, busy, s_reg.step, s_reg.act};
        seq_pkg::A_PTS:   s_next.rdata = s_reg.pts;
        default:          s_next.rdata = 32'h0;
      endcase
    end
    // Register writes
    if (wr)
    begin
      case (paddr)
        seq_pkg::A_CTRL:  s_next.ctrl_w = pwdata[seq_pkg::CW-1:0];
        seq_pkg::A_ONCE:  s_next.once_cnt = pwdata[seq_pkg::RW-1:0]; // [R14]
        seq_pkg::A_TADDR: s_next.taddr = pwdata[seq_pkg::IW-1:0];
        seq_pkg::A_TDATA: s_next.taddr = s_reg.taddr + 10'h001;
        seq_pkg::A_SYNC:  s_next.tgt = pwdata[seq_pkg::IW-1:0];
        seq_pkg::A_SEL:
        begin
          if (!s_reg.ctrl[seq_pkg::P_SRC] && 32'(pwdata[9:0]) < SEQ_N) // [R3]
          begin
            s_next.req  = pwdata[seq_pkg::IW-1:0]; // [R1]
            s_next.pend = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // External select latched only on its valid strobe
    if (s_reg.ctrl[seq_pkg::P_SRC] && sel_valid && 32'(sel_code) < SEQ_N) // [R22]
    begin
      s_next.req  = {2'h0, sel_code};
      s_next.pend = 1'b1;
    end
    // Common selection in coupled operation
    if (s_reg.ctrl[seq_pkg::P_COUP] && common_stb && 32'(common_seq) < SEQ_N) // [R2]
    begin
      s_next.req  = common_seq;
      s_next.pend = 1'b1;
    end
    // Sample points of the running sequence, cleared at its end and when idle
    s_next.acc  = busy ? acc_in : 32'h0;
    // Sync marker follows the locked segment or sequence
    s_next.sync = busy & (s_reg.ctrl[seq_pkg::P_SLOCK] ? (s_reg.act == s_reg.tgt) :
                  (s_reg.seg == s_reg.tgt[seq_pkg::SW-1:0])); // [R20]
    // Jump latch, set only in ST_GO and ST_PLAY; a jump in a clearing cycle is lost
    if (s_reg.st inside {seq_pkg::ST_GO, seq_pkg::ST_PLAY} && jev)
      s_next.jmp = 1'b1;
    case (s_reg.st)
      seq_pkg::ST_IDLE:
      begin
        if (start && !abort)
        begin
          s_next.step = first_a;
          s_next.st   = seq_pkg::ST_GO;
        end
      end
      seq_pkg::ST_GO:
      begin
        s_next.seg = ent[seq_pkg::P_SEG +: seq_pkg::SW]; // [R7]
        s_next.go  = 1'b1;
        s_next.st  = seq_pkg::ST_PLAY;
      end
      seq_pkg::ST_PLAY:
      begin
        // Decisions only at the end of a complete pass
        if (seg_end) // [R10]
        begin
          if (flag && !(s_reg.jmp || jev))
            s_next.st = seq_pkg::ST_GO; // [R9]
          else if (!flag && (s_reg.rep + 20'h00001) < rep_e)
          begin
            s_next.rep = s_reg.rep + 20'h00001; // [R8]
            s_next.st  = seq_pkg::ST_GO;
          end
          else
            s_next.st = seq_pkg::ST_NEXT;
        end
      end
      seq_pkg::ST_NEXT:
      begin
        s_next.rep = '0;
        s_next.jmp = 1'b0;
        s_next.st  = seq_pkg::ST_GO;
        if (s_reg.step != last_a)
          s_next.step = s_reg.step + 10'h001; // [R6]
        else
        begin
          s_next.pts  = acc_in; // [R19]
          s_next.acc  = 32'h0;
          s_next.step = first_a; // [R11]
          if (mode == seq_pkg::ADV_ONCE)
          begin
            // Burst of whole sequences, then idle at the first step
            if ((s_reg.burst + 20'h00001) >= s_reg.once_cnt) // [R14]
            begin
              s_next.burst = '0; // [R23]
              s_next.st    = seq_pkg::ST_IDLE; // [R13]
            end
            else
              s_next.burst = s_reg.burst + 20'h00001;
          end
          else if (s_reg.pend && s_reg.ctrl[seq_pkg::P_ADVT])
          begin
            // Coherent switch at the end of the sequence
            s_next.act  = s_reg.req; // [R4]
            s_next.step = first_r;
            s_next.pend = 1'b0;
          end
        end
      end
      default: s_next.st = seq_pkg::ST_IDLE;
    endcase
    // Immediate switch in advanced operation
    if (s_reg.ctrl[seq_pkg::P_ADVT] && s_reg.ctrl[seq_pkg::P_IMM] && s_reg.pend) // [R18]
    begin
      s_next.act  = s_reg.req; // [R4]
      s_next.pend = 1'b0;
      s_next.step = first_r;
      s_next.rep  = '0;
      s_next.jmp  = 1'b0;
      if (busy)
        s_next.st = seq_pkg::ST_GO;
    end
    // Apply loads staged settings and restarts output
    if (apply)
    begin
      s_next.ctrl  = s_reg.ctrl_w; // [R21]
      s_next.act   = s_reg.req;
      s_next.pend  = 1'b0;
      s_next.step  = first_r;
      s_next.rep   = '0;
      s_next.burst = '0;
      s_next.jmp   = 1'b0;
      if (busy)
        s_next.st = seq_pkg::ST_GO;
    end
    // Abort returns to idle at the first step
    if (abort)
    begin
      s_next.st    = seq_pkg::ST_IDLE; // [R23]
      s_next.step  = apply ? first_r : first_a;
      s_next.rep   = '0;
      s_next.burst = '0;
      s_next.jmp   = 1'b0;
      s_next.go    = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg          <= '0;
      s_reg.st       <= seq_pkg::ST_IDLE;
      s_reg.ctrl     <= seq_pkg::CTRL_RST; // [R12]
      s_reg.ctrl_w   <= seq_pkg::CTRL_RST;
      s_reg.once_cnt <= seq_pkg::ONCE_RST;
    end
    else
      s_reg <= s_next;
  end

  // Playback outputs
  assign seg_num  = s_reg.seg;
  assign seg_go   = s_reg.go;
  assign playing  = busy;
  assign sync_out = s_reg.sync;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rep;
    s_reg.st == seq_pkg::ST_PLAY && seg_end && !flag && (s_reg.rep + 20'h00001) < rep_e
      && !abort && !apply && !s_reg.pend |=> s_reg.st == seq_pkg::ST_GO
      && s_reg.step == $past(s_reg.step) ##1 seg_go;
  endproperty
  a_rep: assert property (p_rep) else $error("repeat pass not replayed"); // [R8]
  property p_dwell;
    s_reg.st == seq_pkg::ST_PLAY && seg_end && flag && !s_reg.jmp && !jev && !abort
      && !apply && !s_reg.pend |=> s_reg.st == seq_pkg::ST_GO && s_reg.rep == $past(s_reg.rep);
  endproperty
  a_dwell: assert property (p_dwell) else $error("flagged step left without jump"); // [R9]
  property p_pass;
    s_reg.st == seq_pkg::ST_PLAY && !seg_end && !abort && !apply && !s_reg.pend
      |=> s_reg.st == seq_pkg::ST_PLAY;
  endproperty
  a_pass: assert property (p_pass) else $error("pass cut short"); // [R10]
  property p_order;
    s_reg.st == seq_pkg::ST_NEXT && s_reg.step != last_a && !abort && !apply && !s_reg.pend
      |=> s_reg.step == $past(s_reg.step) + 10'h001;
  endproperty
  a_order: assert property (p_order) else $error("step order broken"); // [R6]
  property p_wrap;
    seq_end && mode != seq_pkg::ADV_ONCE && !s_reg.pend && !abort && !apply
      |=> s_reg.step == $past(first_a) && s_reg.st == seq_pkg::ST_GO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to first step"); // [R11]
  property p_burst;
    seq_end && mode == seq_pkg::ADV_ONCE && (s_reg.burst + 20'h00001) >= s_reg.once_cnt
      && !apply |=> s_reg.st == seq_pkg::ST_IDLE && s_reg.burst == '0 ##1 !seg_go;
  endproperty
  a_burst: assert property (p_burst) else $error("burst did not end"); // [R14]
  property p_abort;
    abort |=> !playing && s_reg.rep == '0 && s_reg.burst == '0;
  endproperty
  a_abort: assert property (p_abort) else $error("abort left state"); // [R23]
  property p_stepped;
    mode == seq_pkg::ADV_STEP && s_reg.st == seq_pkg::ST_PLAY && seg_end && !s_reg.jmp
      && !jev && !abort && !apply && !s_reg.pend |=> s_reg.st == seq_pkg::ST_GO;
  endproperty
  a_stepped: assert property (p_stepped) else $error("stepped advanced alone"); // [R16]
  property p_pts;
    seq_end && !abort |=> s_reg.pts == $past(acc_in);
  endproperty
  a_pts: assert property (p_pts) else $error("point count wrong"); // [R19]
  property p_coh;
    s_reg.st == seq_pkg::ST_PLAY && !s_reg.ctrl[seq_pkg::P_IMM] && !apply
      |=> s_reg.act == $past(s_reg.act);
  endproperty
  a_coh: assert property (p_coh) else $error("switched mid sequence"); // [R4]
  property p_apply;
    apply |=> s_reg.ctrl == $past(s_reg.ctrl_w) && !s_reg.pend;
  endproperty
  a_apply: assert property (p_apply) else $error("apply not loaded"); // [R21]
  c_once: cover property (seq_end && mode == seq_pkg::ADV_ONCE ##1 !playing);
  c_dwell: cover property (s_reg.st == seq_pkg::ST_PLAY && seg_end && flag && !s_reg.jmp);
  c_wrap: cover property (seq_end && mode == seq_pkg::ADV_AUTO);
  c_imm: cover property (s_reg.pend && s_reg.ctrl[seq_pkg::P_IMM] && playing);
endmodule : waveform_sequence_stepper

/* testbench/playback_model.sv */
`timescale 1ns/1ps
// Segment playback stand-in: one seg_end per seg_go, prompt or slow
module playback_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic seg_go,
  input  wire logic slow,
  output logic      seg_end,
  output logic      sample_tick
);
  logic [3:0] cnt;
  logic       busy;

  // Count a pass down, tick each point, pulse seg_end at its end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt         <= 4'h0;
      busy        <= 1'b0;
      seg_end     <= 1'b0;
      sample_tick <= 1'b0;
    end
    else
    begin
      seg_end     <= 1'b0;
      sample_tick <= busy;
      if (seg_go)
      begin
        busy <= 1'b1;
        cnt  <= slow ? 4'h6 : 4'h1;
      end
      else if (busy)
      begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1)
        begin
          busy    <= 1'b0;
          seg_end <= 1'b1;
        end
      end
    end
  end
endmodule : playback_model

/* testbench/waveform_sequence_stepper_tb.sv */
`timescale 1ns/1ps
module waveform_sequence_stepper_tb;
  logic [7:0]  paddr, seg_num, sel_code;
  logic [31:0] pwdata, prdata, rd;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic        seg_go, seg_end, sample_tick, playing, sync_out;
  logic [6:0]  strb;
  logic [9:0]  common_seq;
  logic [7:0]  segq[$];
  logic [31:0] tbl[5] = '{32'h205, 32'h107, 32'h109, 32'h1000010b, 32'h10c};
  int          num_errors, n_tests, i, n0;

  waveform_sequence_stepper i_waveform_sequence_stepper (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seg_num(seg_num), .seg_go(seg_go), .seg_end(seg_end), .sample_tick(sample_tick),
    .playing(playing), .sync_out(sync_out), .enable_in(strb[6]), .initiate_in(strb[0]),
    .abort_in(strb[1]), .trig_in(strb[2]), .event_in(strb[3]), .sel_code(sel_code),
    .sel_valid(strb[4]), .common_seq(common_seq), .common_stb(strb[5]));

  playback_model i_playback_model (
    .pclk(pclk), .presetn(presetn), .seg_go(seg_go), .slow(slow),
    .seg_end(seg_end), .sample_tick(sample_tick));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Record the segment of every pass started
  always @(posedge pclk)
    if (seg_go === 1'b1)
      segq.push_back(seg_num);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic fail_out;
    num_errors++;
    test_done();
  endtask : fail_out

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (k == 20)
      fail_out();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input int b);
    @(posedge pclk);
    strb[b] <= 1'b1;
    @(posedge pclk);
    strb[b] <= 1'b0;
  endtask : pulse

  task automatic wait_q(input int n);
    int k;
    for (k = 0; k < 3000 && segq.size() < n; k++)
      @(posedge pclk);
    if (k == 3000)
      fail_out();
  endtask : wait_q

  task automatic wait_idle;
    int k;
    for (k = 0; k < 3000 && playing !== 1'b0; k++)
      @(posedge pclk);
    if (k == 3000)
      fail_out();
  endtask : wait_idle

  task automatic t_reset;
    apb(1'b0, seq_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, seq_pkg::A_ONCE, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask : t_reset

  // Park in triggered run, then two sequences of defined segments only
  task automatic t_load;
    apb(1'b1, seq_pkg::A_CTRL, 32'h80);
    apb(1'b1, seq_pkg::A_CMD, 32'h5);
    apb(1'b1, seq_pkg::A_TADDR, 32'h0);
    for (i = 0; i < 5; i++)
      apb(1'b1, seq_pkg::A_TDATA, tbl[i]);
    apb(1'b1, seq_pkg::A_SDEF, 32'h00200000);
    apb(1'b1, seq_pkg::A_SDEF, 32'h00400c01);
  endtask : t_load

  // Once mode, burst of two, slow playback
  task automatic t_once;
    slow <= 1'b1;
    apb(1'b1, seq_pkg::A_CTRL, 32'h81);
    apb(1'b1, seq_pkg::A_ONCE, 32'h2);
    apb(1'b1, seq_pkg::A_CMD, 32'h1);
    segq.delete();
    pulse(0);
    wait_q(8);
    wait_idle();
    chk(segq.size(), 32'h8);
    for (i = 0; i < 8; i++)
      chk(segq[i], (i % 4 < 2) ? 32'h5 : (i % 4 == 2) ? 32'h7 : 32'h9);
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[20:10], 32'h0);
  endtask : t_once

  // Stepped mode: dwell on every step, wrong source ignored
  task automatic t_step;
    slow <= 1'b0;
    apb(1'b1, seq_pkg::A_CTRL, 32'h82);
    apb(1'b1, seq_pkg::A_CMD, 32'h1);
    segq.delete();
    pulse(0);
    wait_q(3);
    pulse(2);
    wait_q(6);
    n0 = segq.size();
    chk(segq[n0 - 1], 32'h5);
    pulse(3);
    wait_q(n0 + 4);
    chk(segq[n0 + 1], 32'h7);
    chk(segq[n0 + 2], 32'h7);
    pulse(1);
    wait_idle();
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[19:10], 32'h0);
  endtask : t_step

  // External select: latched only on the valid strobe
  task automatic t_sel;
    sel_code <= 8'h02;
    apb(1'b1, seq_pkg::A_CTRL, 32'h88);
    apb(1'b1, seq_pkg::A_CMD, 32'h5);
    apb(1'b1, seq_pkg::A_SEL, 32'h1);
    apb(1'b1, seq_pkg::A_CMD, 32'h5);
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[9:0], 32'h0);
    pulse(4);
    apb(1'b1, seq_pkg::A_CMD, 32'h5);
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[9:0], 32'h2);
  endtask : t_sel

  // Auto, continuous, jump on trigger input, sequence 1 wraps
  task automatic t_auto;
    apb(1'b1, seq_pkg::A_CTRL, 32'ha0);
    apb(1'b1, seq_pkg::A_CMD, 32'h5);
    apb(1'b1, seq_pkg::A_SEL, 32'h1);
    apb(1'b1, seq_pkg::A_CTRL, 32'h20);
    segq.delete();
    apb(1'b1, seq_pkg::A_CMD, 32'h1);
    wait_q(2);
    pulse(3);
    wait_q(4);
    n0 = segq.size();
    chk(segq[n0 - 1], 32'hb);
    pulse(2);
    wait_q(n0 + 4);
    // One of the two passes is the second step, the other the wrap
    chk(32'(segq[n0]) + 32'(segq[n0 + 1]), 32'h17);
    chk(segq[n0 + 2], 32'hb);
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[9:0], 32'h1);
  endtask : t_auto

  // Advanced type: common selection switches only at sequence end
  task automatic t_adv;
    apb(1'b1, seq_pkg::A_CTRL, 32'h624);
    apb(1'b1, seq_pkg::A_CMD, 32'h1);
    pulse(5);
    wait_q(segq.size() + 3);
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[9:0], 32'h1);
    chk(sync_out, 32'h0);
    pulse(2);
    n0 = segq.size();
    wait_q(n0 + 10);
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[9:0], 32'h0);
    chk(sync_out, 32'h1);
    // One point per prompt pass, four passes in sequence 0
    apb(1'b0, seq_pkg::A_PTS, 32'h0);
    chk(rd, 32'h4);
  endtask : t_adv

  // Once mode in continuous run stays idle until the enable input starts it
  task automatic t_en;
    apb(1'b1, seq_pkg::A_CTRL, 32'h1);
    apb(1'b1, seq_pkg::A_ONCE, 32'h1);
    apb(1'b1, seq_pkg::A_CMD, 32'h5);
    apb(1'b0, seq_pkg::A_STAT, 32'h0);
    chk(rd[20], 32'h0);
    segq.delete();
    pulse(6);
    wait_q(4);
    wait_idle();
    chk(segq.size(), 32'h4);
  endtask : t_en

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    strb = 7'h00;
    sel_code = 8'h00;
    common_seq = 10'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_load();
    t_once();
    t_step();
    t_sel();
    t_auto();
    t_adv();
    t_en();
    test_done();
  end
endmodule : waveform_sequence_stepper_tb
